// >>> logic/epsc_counter.v
// One wrapping statistic counter with clear priority.
`include "epsc_map.vh"
module epsc_counter #(
	parameter WIDTH = `EPSC_CNT_WIDTH
) (
	input wire i_clock,
	input wire i_reset_n,
	input wire i_clear,
	input wire i_inc,
	output reg [WIDTH-1:0] o_count
);
	always @(posedge i_clock) begin
		if (!i_reset_n || i_clear) begin
			o_count <= {WIDTH{1'b0}};
		end else if (i_inc) begin
			o_count <= o_count + {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end
endmodule

// >>> logic/epsc_map.vh
// Constants for the network port statistic counter bank.
`ifndef EPSC_MAP_VH
`define EPSC_MAP_VH
`define EPSC_NUM_COUNTERS 32
`define EPSC_CNT_WIDTH 16
`define EPSC_BUF_LIMIT_RST 8'h10
`define EPSC_COLL_LIMIT 5'h10
`define EPSC_CLK_HZ 10000000
`define EPSC_LAMP_MS 1000
`define EPSC_LAMP_CYCLES ((`EPSC_CLK_HZ / 1000) * `EPSC_LAMP_MS)
`define EPSC_ROUTE_FIELDS 8
`define EPSC_ROUTE_UNUSED 8'hFF
`define EPSC_IDX_RX_VALID 0
`define EPSC_IDX_RX_NOBUF 1
`define EPSC_IDX_RETRY_RX 2
`define EPSC_IDX_GEN 3
`define EPSC_IDX_GEN_FAIL 4
`define EPSC_IDX_TX_ACK 5
`define EPSC_IDX_TX_LOST 6
`define EPSC_IDX_TX_RETRY 7
`define EPSC_IDX_UNROUTE 8
`define EPSC_IDX_ILLEGAL 9
`define EPSC_IDX_PRI_RD 10
`define EPSC_IDX_PRI_WR 11
`define EPSC_IDX_NP_RD 12
`define EPSC_IDX_NP_WR 13
`define EPSC_IDX_FOREIGN 14
`define EPSC_IDX_FR_TX 15
`define EPSC_IDX_FR_RX 16
`define EPSC_IDX_COLL 17
`define EPSC_IDX_COLL_LOST 18
`define EPSC_ERR_MASK 32'h0004_03D2
`endif

// >>> logic/epsc_stat_bank.v
// Statistic counter bank, route snapshot and error lamp for the network port.
// Functional notes
// - Thirty-two counters per port, each advancing by one on its event; only counters 0 to 18 have an event, 19 to 31 stay at zero.
// - Any error counter advance lights the red error lamp for one second.
// - A clear request zeroes all counters at once; reader issues it on demand.
// - Count valid command or reply frames accepted from a peer.
// - Count incoming frames dropped for no free buffer; limit defaults to 16.
// - Count retry requests from peers for messages this port routed.
// - Count messages the port originates itself, such as periodic transfers.
// - Count internal originations that fail for lack of a buffer.
// - Count transmissions completed with a positive acknowledgement.
// - Count a retry on each negative or missing acknowledgement.
// - When retries run out, drop the frame and count it lost.
// - Count received frames discarded because the route is unresolvable.
// - Count received requests with an illegal operation code.
// - Separate counters for locally served priority reads and writes.
// - Separate counters for locally served non-priority reads and writes.
// - Count every command, reply, ACK, NAK or BUSY frame transmitted.
// - Count every command, reply, ACK, NAK or BUSY frame received.
// - Hold eight route fields of the last message; unused marked; zero initially.
// - Count collisions between own transmission and other traffic.
// - Counter for non-native frames in alternate mode; may stay inactive.
// - Abandon a frame and report error after more than 16 collisions.
`include "epsc_map.vh"
module epsc_stat_bank #(
	parameter CNT_WIDTH = `EPSC_CNT_WIDTH,
	parameter LAMP_CYCLES = `EPSC_LAMP_CYCLES,
	parameter [7:0] BUF_LIMIT_DEFAULT = `EPSC_BUF_LIMIT_RST
) (
	input wire i_clock,
	input wire i_reset_n,
	input wire i_clear,

	// One-cycle event pulses from the protocol engine on the same clock.
	input wire i_ev_rx_valid,
	input wire i_ev_rx_nobuf,
	input wire i_ev_retry_rx,
	input wire i_ev_gen,
	input wire i_ev_gen_fail,
	input wire i_ev_tx_ack,
	input wire i_ev_tx_nak,
	input wire i_ev_tx_timeout,
	input wire i_ev_tx_retries_out,
	input wire i_ev_unroute,
	input wire i_ev_illegal,
	input wire i_ev_pri_rd,
	input wire i_ev_pri_wr,
	input wire i_ev_np_rd,
	input wire i_ev_np_wr,
	input wire i_ev_foreign,
	input wire i_ev_frame_tx,
	input wire i_ev_frame_rx,
	input wire i_ev_tx_start,
	input wire i_ev_collision,

	// Buffer limit setting written by the configuration side.
	input wire i_buf_limit_wr,
	input wire [7:0] i_buf_limit,

	// Route of the most recent incoming message.
	input wire i_route_load,
	input wire [3:0] i_route_len,
	input wire [63:0] i_route,

	// Counter index shown on the single read port.
	input wire [4:0] i_sel,

	// Every output is registered.
	output reg [CNT_WIDTH-1:0] o_count,
	output reg [(`EPSC_NUM_COUNTERS*CNT_WIDTH)-1:0] o_counts,
	output reg [63:0] o_last_route,
	output reg [7:0] o_buf_limit,
	output reg o_coll_abort,
	output reg o_error_lamp
);
	localparam N = `EPSC_NUM_COUNTERS;
	localparam [N-1:0] ERR_MASK = `EPSC_ERR_MASK;
	localparam [4:0] COLL_LIMIT = `EPSC_COLL_LIMIT;

	wire [N-1:0] inc;
	wire [N*CNT_WIDTH-1:0] counts;
	reg [4:0] coll_count;
	reg [31:0] lamp_timer;
	reg [CNT_WIDTH-1:0] next_count;
	wire coll_excess;
	integer k;
	reg [4:0] next_coll_count;
	reg [31:0] next_lamp_timer;
	reg [1:0] lamp_state;
	reg [1:0] next_lamp_state;
	reg [7:0] next_buf_limit;
	wire err_event;
	localparam [1:0] LAMP_DARK = 2'b01;
	localparam [1:0] LAMP_LIT = 2'b10;
	localparam [31:0] LAMP_LOAD = LAMP_CYCLES - 1;

	// Any advance of an error-class counter lights the lamp.
	assign err_event = |(inc & ERR_MASK);

	// A collision that pushes the count past the limit abandons the frame.
	assign coll_excess = i_ev_collision && (coll_count == COLL_LIMIT) && !i_ev_tx_start;

	assign inc[`EPSC_IDX_RX_VALID] = i_ev_rx_valid;
	assign inc[`EPSC_IDX_RX_NOBUF] = i_ev_rx_nobuf;
	assign inc[`EPSC_IDX_RETRY_RX] = i_ev_retry_rx;
	assign inc[`EPSC_IDX_GEN] = i_ev_gen;
	assign inc[`EPSC_IDX_GEN_FAIL] = i_ev_gen_fail;
	assign inc[`EPSC_IDX_TX_ACK] = i_ev_tx_ack;
	assign inc[`EPSC_IDX_TX_LOST] = i_ev_tx_retries_out;
	assign inc[`EPSC_IDX_TX_RETRY] = i_ev_tx_nak | i_ev_tx_timeout;
	assign inc[`EPSC_IDX_UNROUTE] = i_ev_unroute;
	assign inc[`EPSC_IDX_ILLEGAL] = i_ev_illegal;
	assign inc[`EPSC_IDX_PRI_RD] = i_ev_pri_rd;
	assign inc[`EPSC_IDX_PRI_WR] = i_ev_pri_wr;
	assign inc[`EPSC_IDX_NP_RD] = i_ev_np_rd;
	assign inc[`EPSC_IDX_NP_WR] = i_ev_np_wr;
	assign inc[`EPSC_IDX_FOREIGN] = i_ev_foreign;
	assign inc[`EPSC_IDX_FR_TX] = i_ev_frame_tx;
	assign inc[`EPSC_IDX_FR_RX] = i_ev_frame_rx;
	assign inc[`EPSC_IDX_COLL] = i_ev_collision;
	assign inc[`EPSC_IDX_COLL_LOST] = coll_excess;
	assign inc[N-1:`EPSC_IDX_COLL_LOST+1] = {(N-`EPSC_IDX_COLL_LOST-1){1'b0}};

	genvar g;
	generate
		for (g = 0; g < N; g = g + 1) begin : gen_cnt
			epsc_counter #(
				.WIDTH(CNT_WIDTH)
			) u_cnt (
				.i_clock(i_clock),
				.i_reset_n(i_reset_n),
				.i_clear(i_clear),
				.i_inc(inc[g]),
				.o_count(counts[g*CNT_WIDTH +: CNT_WIDTH])
			);
		end
	endgenerate

	always @* begin
		next_count = {CNT_WIDTH{1'b0}};
		for (k = 0; k < N; k = k + 1) begin
			if (i_sel == k[4:0]) begin
				next_count = counts[k*CNT_WIDTH +: CNT_WIDTH];
			end
		end
	end

	// The selected counter is shown one cycle after its update.
	always @(posedge i_clock) begin
		if (!i_reset_n) begin
			o_count <= {CNT_WIDTH{1'b0}};
		end else begin
			o_count <= next_count;
		end
	end

	// The full bank copy lags the live counters by the same one cycle.
	always @(posedge i_clock) begin
		if (!i_reset_n) begin
			o_counts <= {(N*CNT_WIDTH){1'b0}};
		end else begin
			o_counts <= counts;
		end
	end

	// Collision tally per transmission attempt; a new attempt restarts it.
	always @* begin
		next_coll_count = coll_count;
		if (i_ev_tx_start || coll_excess) begin
			next_coll_count = 5'h00;
		end else if (i_ev_collision) begin
			next_coll_count = coll_count + 5'h01;
		end
	end

	always @(posedge i_clock) begin
		if (!i_reset_n) begin
			coll_count <= 5'h00;
			o_coll_abort <= 1'b0;
		end else begin
			coll_count <= next_coll_count;
			o_coll_abort <= coll_excess;
		end
	end

	always @* begin
		next_buf_limit = o_buf_limit;
		if (i_buf_limit_wr) begin
			next_buf_limit = i_buf_limit;
		end
	end

	always @(posedge i_clock) begin
		if (!i_reset_n) begin
			o_buf_limit <= BUF_LIMIT_DEFAULT;
		end else begin
			o_buf_limit <= next_buf_limit;
		end
	end

	// Route snapshot; positions at or beyond the length are marked unused.
	generate
		for (g = 0; g < `EPSC_ROUTE_FIELDS; g = g + 1) begin : gen_route
			always @(posedge i_clock) begin
				if (!i_reset_n) begin
					o_last_route[g*8 +: 8] <= 8'h00;
				end else if (i_route_load) begin
					if (i_route_len > g) begin
						o_last_route[g*8 +: 8] <= i_route[g*8 +: 8];
					end else begin
						o_last_route[g*8 +: 8] <= `EPSC_ROUTE_UNUSED;
					end
				end
			end
		end
	endgenerate

	// Any error counter advance restarts the one second lamp hold.
	// The lamp stays lit for LAMP_CYCLES cycles after the last error event.
	always @* begin
		next_lamp_state = lamp_state;
		next_lamp_timer = lamp_timer;
		case (lamp_state)
			LAMP_DARK: begin
				if (err_event) begin
					next_lamp_state = LAMP_LIT;
					next_lamp_timer = LAMP_LOAD;
				end
			end
			LAMP_LIT: begin
				if (err_event) begin
					next_lamp_timer = LAMP_LOAD;
				end else if (lamp_timer != 32'h0000_0000) begin
					next_lamp_timer = lamp_timer - 32'h0000_0001;
				end else begin
					next_lamp_state = LAMP_DARK;
				end
			end
			default: begin
				next_lamp_state = LAMP_DARK;
				next_lamp_timer = 32'h0000_0000;
			end
		endcase
	end

	always @(posedge i_clock) begin
		if (!i_reset_n) begin
			lamp_state <= LAMP_DARK;
			lamp_timer <= 32'h0000_0000;
			o_error_lamp <= 1'b0;
		end else begin
			lamp_state <= next_lamp_state;
			lamp_timer <= next_lamp_timer;
			o_error_lamp <= (next_lamp_state == LAMP_LIT);
		end
	end
endmodule

// >>> tb/epsc_engine_model.sv
// Protocol engine and reader model that turns a mask into event pulses.
module epsc_engine_model (
	input wire logic i_clock,
	input wire logic i_go,
	input wire logic [20:0] i_mask,
	output logic [20:0] o_ev
);
	timeunit 1ns;
	timeprecision 1ns;
	initial o_ev = 21'h000000;
	// Bit 20 is the reader's clear request, raised only on operator demand.
	always @(posedge i_clock) o_ev <= i_go ? i_mask : 21'h000000;
endmodule

// >>> tb/epsc_stat_bank_properties.sv
// Concurrent checks on the statistic counter bank ports.
module epsc_stat_bank_properties (
	input logic i_clock, i_reset_n, i_clear, i_ev_rx_valid, i_ev_unroute, i_ev_collision,
	input logic i_buf_limit_wr, i_route_load, o_coll_abort, o_error_lamp,
	input logic [7:0] i_buf_limit, o_buf_limit,
	input logic [3:0] i_route_len,
	input logic [4:0] i_sel,
	input logic [15:0] o_count,
	input logic [63:0] i_route, o_last_route,
	input logic [511:0] o_counts
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_reset_n);
	clear_zero_a: assert property (i_clear |-> ##2 o_count == 16'h0000) else $error("count not cleared");
	count_step_a: assert property (i_ev_rx_valid && !i_clear |-> ##2 o_counts[15:0] == $past(o_counts[15:0]) + 16'h0001)
		else $error("count did not step");
	lamp_held_a: assert property (i_ev_unroute |=> o_error_lamp [*8]) else $error("lamp not held");
	limit_write_a: assert property (i_buf_limit_wr |=> o_buf_limit == $past(i_buf_limit)) else $error("limit lost");
	route_part_a: assert property (i_route_load && i_route_len == 4'h3 |=>
		o_last_route == {40'hFFFFFFFFFF, $past(i_route[23:0])}) else $error("route wrong");
	abort_cause_a: assert property (o_coll_abort |-> $past(i_ev_collision) && !$past(o_coll_abort))
		else $error("stray abort");
	sel_view_a: assert property (o_count == o_counts[$past(i_sel)*16 +: 16]) else $error("selected count wrong");
	spare_idle_a: assert property (o_counts[511:304] == 0) else $error("spare counter moved");
endmodule

bind epsc_stat_bank epsc_stat_bank_properties chk (.i_clock, .i_reset_n, .i_clear, .i_ev_rx_valid, .i_ev_unroute,
	.i_ev_collision, .i_buf_limit_wr, .i_route_load, .o_coll_abort, .o_error_lamp, .i_buf_limit, .o_buf_limit,
	.i_route_len, .i_sel, .o_count, .i_route, .o_last_route, .o_counts);

// >>> tb/epsc_stat_bank_tb.sv
// Self-checking bench for the statistic counter bank.
module epsc_stat_bank_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_clock = 0, i_reset_n = 0, go = 0, wr = 0, ld = 0;
	logic [20:0] m = 0;
	logic [7:0] lim = 0;
	logic [3:0] len = 0;
	logic [4:0] sel = 0;
	logic [63:0] rt = 0;
	wire [20:0] e;
	wire [15:0] cnt;
	wire [511:0] cnts;
	wire [63:0] lr;
	wire [7:0] bl;
	wire lamp, abort;
	integer n_mismatch = 0, comparisons = 0, k, n_abort = 0;
	always #50 i_clock = ~i_clock;
	always @(posedge i_clock) if (abort === 1'b1) n_abort++;
	epsc_engine_model eng (.i_clock(i_clock), .i_go(go), .i_mask(m), .o_ev(e));
	epsc_stat_bank #(.LAMP_CYCLES(20)) uut (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_clear(e[20]),
		.i_ev_rx_valid(e[0]), .i_ev_rx_nobuf(e[1]), .i_ev_retry_rx(e[2]), .i_ev_gen(e[3]), .i_ev_gen_fail(e[4]),
		.i_ev_tx_ack(e[5]), .i_ev_tx_retries_out(e[6]), .i_ev_tx_nak(e[7]), .i_ev_unroute(e[8]), .i_ev_illegal(e[9]),
		.i_ev_pri_rd(e[10]), .i_ev_pri_wr(e[11]), .i_ev_np_rd(e[12]), .i_ev_np_wr(e[13]), .i_ev_foreign(e[14]),
		.i_ev_frame_tx(e[15]), .i_ev_frame_rx(e[16]), .i_ev_collision(e[17]), .i_ev_tx_timeout(e[18]),
		.i_ev_tx_start(e[19]), .i_buf_limit_wr(wr), .i_buf_limit(lim), .i_route_load(ld), .i_route_len(len),
		.i_route(rt), .i_sel(sel), .o_count(cnt), .o_counts(cnts), .o_last_route(lr), .o_buf_limit(bl),
		.o_coll_abort(abort), .o_error_lamp(lamp));
	task chk(input logic [63:0] got, input logic [63:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Raises the mask for n back-to-back cycles, then lets the outputs settle.
	task pulse(input logic [20:0] mk, input integer n);
		@(posedge i_clock) #1 go = 1;
		m = mk;
		repeat (n) @(posedge i_clock);
		#1 go = 0;
		repeat (4) @(posedge i_clock);
		#1;
	endtask
	task print_verdict;
		$display("Counts: %0d mismatches in %0d comparisons", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge i_clock);
		#1 i_reset_n = 1;
		chk(bl, 8'h10);
		chk(lr, 0);
		$display("Test reset ended");
		for (k = 0; k < 18; k++) pulse(21'h1 << k, 1);
		pulse(21'h40080, 1);
		for (k = 0; k < 20; k++) chk(cnts[k*16 +: 16], (k == 7) ? 2 : (k > 17) ? 0 : 1);
		sel = 5'h07;
		repeat (2) @(posedge i_clock);
		#1 chk(cnt, 16'h0002);
		chk(lamp, 1);
		repeat (24) @(posedge i_clock);
		#1 chk(lamp, 0);
		pulse(21'h000001, 1);
		chk(lamp, 0);
		pulse(21'h000200, 1);
		chk(lamp, 1);
		$display("Test events and lamp ended");
		pulse(21'h080000, 1);
		pulse(21'h020000, 16);
		chk(cnts[18*16 +: 16], 0);
		pulse(21'h020000, 1);
		chk(cnts[18*16 +: 16], 1);
		chk(cnts[17*16 +: 16], 18);
		chk(n_abort, 1);
		pulse(21'h080000, 1);
		pulse(21'h020000, 16);
		chk(cnts[18*16 +: 16], 1);
		chk(n_abort, 1);
		$display("Test collisions ended");
		@(posedge i_clock) #1 wr = 1;
		{lim, ld, len, rt} = {8'h05, 1'b1, 4'h3, 64'h0807060504030201};
		@(posedge i_clock) #1 wr = 0;
		ld = 0;
		repeat (2) @(posedge i_clock);
		#1 chk(bl, 8'h05);
		chk(lr, 64'hFFFFFFFFFF030201);
		@(posedge i_clock) #1 {ld, len} = {1'b1, 4'h0};
		@(posedge i_clock) #1 ld = 0;
		@(posedge i_clock) #1 chk(lr, 64'hFFFFFFFFFFFFFFFF);
		pulse(21'h100001, 1);
		for (k = 0; k < 32; k++) chk(cnts[k*16 +: 16], 0);
		pulse(21'h000001, 65537);
		chk(cnts[15:0], 1);
		$display("Test limit, route, clear and wrap ended");
		print_verdict;
	end
endmodule
